/* src/sep_pkg.sv */
package sep_pkg;

  // array geometry: byte index covers both word widths
  localparam int ABITS = 11;
  localparam int MEM_BYTES = 2048;
  localparam logic [11:0] ALL_BYTES = 12'h800;

  // bits after the start bit: opcode plus address, then the data bits
  localparam logic [4:0] CMD_BITS_X16 = 5'h0C;
  localparam logic [4:0] CMD_BITS_X8 = 5'h0D;
  localparam logic [4:0] DAT_BITS_X16 = 5'h10;
  localparam logic [4:0] DAT_BITS_X8 = 5'h08;

  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;

  // top two address bits under the special opcode
  localparam logic [1:0] SUB_WDIS = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL_CMD = 2'h2;
  localparam logic [1:0] SUB_WEN = 2'h3;

  localparam logic [7:0] BYTE_ERASED = 8'hFF;

  // synchroniser bit positions
  localparam int SY_CS = 0;
  localparam int SY_SK = 1;
  localparam int SY_DI = 2;
  localparam int SY_ORG = 3;
  localparam int SY_PE = 4;

  // self-timed program/erase cycle
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_EW_NS = 5000000;
  localparam int T_EW_CYC = T_EW_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 20;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_DATA = 7'h04,
    ST_READ = 7'h08,
    ST_WAITCS = 7'h10,
    ST_BUSY = 7'h20,
    ST_SWEEP = 7'h40
  } sep_state_type;

  typedef enum logic [1:0] {
    PK_ERASE = 2'h0,
    PK_WRITE = 2'h1,
    PK_ERASE_ALL_CMD = 2'h2,
    PK_WRITE_ALL_CMD = 2'h3
  } sep_pend_type;

  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic skp;
    sep_state_type st;
    logic [4:0] cnt;
    logic [12:0] sh;
    sep_pend_type pkind;
    logic pv;
    logic [ABITS-1:0] paddr;
    logic [15:0] pdata;
    logic wel;
    logic stat;
    logic rel;
    logic [TMR_W-1:0] timer;
    logic [ABITS-1:0] sidx;
    logic [11:0] sleft;
    logic [ABITS-1:0] raddr;
    logic [1:0][15:0] buff;
    logic bwp;
    logic brp;
    logic [1:0] bcnt;
    logic [15:0] osh;
    logic [4:0] ocnt;
    logic oe;
    logic dout;
  } sep_regs_type;

endpackage

/* src/sep_command_port.sv */
// Notes on behaviour
// - instruction is 13 bits for 16-bit words, 14 bits for 8-bit words
// - frame: start bit one, two-bit opcode, ten-bit address plus one in x8
// - writing instructions carry 16 or 8 data bits after the address
// - input bits are captured on rising serial clock edges
// - output is high impedance except read data or busy status
// - opcode 10 read, 11 erase, 01 write, 00 special by top address bits
// - enable sets latch, disable clears it; program/erase ignored while clear
// - program and erase need enable pin high; enable/disable do not
// - read drives output, sends one zero, then the word msb first
// - read data bit changes on each rising serial clock edge
// - continued clocking streams next words, wrapping to address 0
// - leading zero only before the first word of a stream
// - select falling after a write starts self-timed clear and store
// - self-timed cycle completes with no further serial clock edges
// - with select high, output low while busy, high when ready
// - a one shifted in during status releases output on next falling edge
// - write clears the word before storing, no separate erase needed
// - erase sets every bit of the addressed word to one
// - erase-all sets every bit of the whole array to one
// - write-all stores one word into every location
// - write-enable latch clear at reset, kept until a disable
// - reads work whatever the latch state
// - width select high picks 16-bit words, low picks 8-bit words
module sep_command_port
  import sep_pkg::*;
#(
  parameter int PROG_CYCLES = T_EW_CYC
)
(
  // system
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // straps
  input wire logic word_width_select,
  input wire logic program_enable_pin,
  // status
  output logic busy,
  output logic write_enabled
);

  sep_regs_type s;
  sep_regs_type n;

  logic [7:0] mem [0:MEM_BYTES-1];

  logic rise;
  logic fall;
  logic cs;
  logic di;
  logic x16;
  logic pe;
  logic [4:0] need_c;
  logic [4:0] need_d;
  logic [12:0] nsh;
  logic [1:0] op;
  logic [1:0] top;
  logic [ABITS-1:0] addr;
  logic [ABITS-1:0] step;
  logic [15:0] head;
  logic [15:0] rword;
  logic pop;
  logic push;
  logic ready;
  logic mem_we;
  logic [ABITS-1:0] mem_idx;
  logic [7:0] mem_val;

  always_comb
  begin
    n = s;
    n.sy1 = {program_enable_pin, word_width_select, serial_in,
             serial_clock_in, chip_select};
    n.sy2 = s.sy1;
    n.skp = s.sy2[SY_SK];
    rise = s.sy2[SY_SK] & ~s.skp;
    fall = ~s.sy2[SY_SK] & s.skp;
    cs = s.sy2[SY_CS];
    di = s.sy2[SY_DI];
    x16 = s.sy2[SY_ORG];
    pe = s.sy2[SY_PE];
    need_c = x16 ? CMD_BITS_X16 : CMD_BITS_X8;
    need_d = x16 ? DAT_BITS_X16 : DAT_BITS_X8;
    nsh = {s.sh[11:0], di};
    // field split of the completed frame
    op = x16 ? nsh[11:10] : nsh[12:11];
    top = x16 ? nsh[9:8] : nsh[10:9];
    addr = x16 ? {nsh[9:0], 1'b0} : nsh[10:0];
    step = {9'h000, x16, ~x16};
    head = x16 ? s.buff[s.brp] : {s.buff[s.brp][7:0], 8'h00};
    rword = x16 ? {mem[{s.raddr[10:1], 1'b0}], mem[{s.raddr[10:1], 1'b1}]}
                : {8'h00, mem[s.raddr]};
    pop = 1'b0;
    push = 1'b0;
    mem_we = 1'b0;
    mem_idx = s.sidx;
    mem_val = BYTE_ERASED;
    unique case (s.st)
      ST_IDLE:
      begin
        if (cs && rise && di)
        begin
          n.st = ST_CMD;
          n.cnt = 5'h00;
          n.sh = 13'h0000;
        end
      end
      ST_CMD:
      begin
        if (!cs)
        begin
          n.st = ST_IDLE;
        end
        else if (rise)
        begin
          n.sh = nsh;
          n.cnt = s.cnt + 5'h01;
          if (s.cnt == need_c - 5'h01)
          begin
            n.cnt = 5'h00;
            n.paddr = addr;
            n.st = ST_WAITCS;
            unique case (op)
              OP_READ:
              begin
                n.st = ST_READ;
                n.raddr = addr;
                n.ocnt = 5'h00;
                n.dout = 1'b0;
              end
              OP_ERASE:
              begin
                n.pkind = PK_ERASE;
                n.pv = 1'b1;
              end
              OP_WRITE:
              begin
                n.pkind = PK_WRITE;
                n.st = ST_DATA;
              end
              OP_SPECIAL:
              begin
                unique case (top)
                  SUB_WEN: n.wel = 1'b1;
                  SUB_WDIS: n.wel = 1'b0;
                  SUB_ERASE_ALL_CMD:
                  begin
                    n.pkind = PK_ERASE_ALL_CMD;
                    n.pv = 1'b1;
                  end
                  SUB_WRITE_ALL_CMD:
                  begin
                    n.pkind = PK_WRITE_ALL_CMD;
                    n.st = ST_DATA;
                  end
                endcase
              end
            endcase
          end
        end
      end
      ST_DATA:
      begin
        if (!cs)
        begin
          n.st = ST_IDLE;
        end
        else if (rise)
        begin
          n.pdata = {s.pdata[14:0], di};
          n.cnt = s.cnt + 5'h01;
          if (s.cnt == need_d - 5'h01)
          begin
            n.st = ST_WAITCS;
            n.pv = 1'b1;
          end
        end
      end
      ST_READ:
      begin
        if (!cs)
        begin
          n.st = ST_IDLE;
        end
        else if (rise)
        begin
          if (s.ocnt != 5'h00)
          begin
            // words follow back to back, no zero between
            n.dout = s.osh[15];
            n.osh = {s.osh[14:0], 1'b0};
            n.ocnt = s.ocnt - 5'h01;
          end
          else if (s.bcnt != 2'h0)
          begin
            pop = 1'b1;
            n.dout = head[15];
            n.osh = {head[14:0], 1'b0};
            n.ocnt = need_d - 5'h01;
          end
        end
      end
      ST_WAITCS:
      begin
        if (!cs)
        begin
          n.pv = 1'b0;
          n.st = ST_IDLE;
          if (s.pv && s.wel && pe)
          begin
            // select falling arms the self-timed cycle
            n.st = ST_BUSY;
            n.stat = 1'b1;
            n.rel = 1'b0;
            n.timer = TMR_W'(PROG_CYCLES);
            if (s.pkind == PK_ERASE_ALL_CMD || s.pkind == PK_WRITE_ALL_CMD)
            begin
              n.sidx = '0;
              n.sleft = ALL_BYTES;
            end
            else
            begin
              n.sidx = s.paddr;
              n.sleft = {10'h000, x16, ~x16};
            end
          end
        end
      end
      ST_BUSY:
      begin
        // counts on clk alone
        n.timer = s.timer - TMR_W'(1);
        if (s.timer <= TMR_W'(1))
        begin
          n.st = ST_SWEEP;
        end
      end
      ST_SWEEP:
      begin
        mem_we = 1'b1;
        // erase kinds leave ones; write kinds overwrite the old word
        if (s.pkind == PK_WRITE || s.pkind == PK_WRITE_ALL_CMD)
        begin
          mem_val = (x16 && !s.sidx[0]) ? s.pdata[15:8] : s.pdata[7:0];
        end
        n.sidx = s.sidx + step - step + 11'h001;
        n.sleft = s.sleft - 12'h001;
        if (s.sleft == 12'h001)
        begin
          n.st = ST_IDLE;
        end
      end
    endcase
    if (n.st == ST_IDLE && s.st != ST_IDLE)
    begin
      n.cnt = 5'h00;
      n.sh = 13'h0000;
    end
    // two-entry prefetch buffer between array and output shifter
    // no fetch in the entry cycle: raddr only takes the frame address then
    if (s.st == ST_READ && n.st == ST_READ &&
        (s.bcnt - {1'b0, pop}) != 2'h2)
    begin
      push = 1'b1;
      n.buff[s.bwp] = rword;
      n.raddr = s.raddr + step;
    end
    if (n.st != ST_READ)
    begin
      n.bcnt = 2'h0;
      n.bwp = 1'b0;
      n.brp = 1'b0;
    end
    else
    begin
      n.bcnt = s.bcnt - {1'b0, pop} + {1'b0, push};
      n.bwp = s.bwp ^ push;
      n.brp = s.brp ^ pop;
    end
    // status release by a shifted one
    if (s.stat && cs && rise && di)
    begin
      n.rel = 1'b1;
    end
    if (s.rel && fall)
    begin
      n.stat = 1'b0;
      n.rel = 1'b0;
    end
    ready = (n.st != ST_BUSY) && (n.st != ST_SWEEP);
    if (n.st != ST_READ)
    begin
      n.dout = n.stat & ready;
    end
    n.oe = cs && (n.st == ST_READ || n.stat);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= ST_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      mem[mem_idx] <= mem_val;
    end
  end

  assign serial_out = s.dout;
  assign serial_out_oe = s.oe;
  assign busy = (s.st == ST_BUSY) || (s.st == ST_SWEEP);
  assign write_enabled = s.wel;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_prog_arm;
    (s.st == ST_WAITCS) && !s.sy2[SY_CS] && s.pv && s.wel && s.sy2[SY_PE];
  endsequence

  sequence s_prog_run;
    (s.st == ST_BUSY) && s.stat;
  endsequence

  a_prog_start: assert property (s_prog_arm |=> s_prog_run)
    else $error("armed program cycle did not start");

  a_latch_gate: assert property ($rose(s.st == ST_BUSY) |->
    $past(s.wel) && $past(s.sy2[SY_PE]))
    else $error("program cycle started without latch or enable pin");

  a_busy_hold: assert property (
    (s.st == ST_BUSY && s.timer > TMR_W'(1)) |=> (s.st == ST_BUSY))
    else $error("self-timed cycle ended early");

  a_status_low: assert property (
    (s.oe && s.stat && busy) |-> !s.dout)
    else $error("status shows ready while busy");

  a_hiz_deselect: assert property (!$past(s.sy2[SY_CS]) |-> !s.oe)
    else $error("output driven while deselected");

  a_read_zero: assert property ($rose(s.st == ST_READ) |->
    s.oe && !s.dout)
    else $error("read did not open with a zero bit");

  a_read_wrap: assert property ((push && (&s.raddr[10:1]) &&
    (x16 || s.raddr[0])) |=> (s.raddr == '0))
    else $error("read address did not wrap to zero");

  a_release_fall: assert property ($fell(s.stat) |->
    $past(s.rel) && $past(fall))
    else $error("status released off a falling clock edge");

  a_idle_reset: assert property ((!cs && (s.st == ST_CMD ||
    s.st == ST_DATA || s.st == ST_READ)) |=> (s.st == ST_IDLE))
    else $error("deselect did not reset the shifter");

  a_latch_clear: assert property ($fell(s.wel) |->
    $past(s.st == ST_CMD))
    else $error("latch cleared without a disable command");

endmodule

/* dv/sep_host_model.sv */
module sep_host_model
(
  // system
  input wire logic clk,
  // link
  output logic chip_select,
  output logic serial_clock_in,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    chip_select = 1'b0;
    serial_clock_in = 1'b0;
    serial_in = 1'b0;
  end

  // one bit: data set while clock low, output sampled before the rise
  task automatic bit_io(input logic b, output logic q);
    serial_in <= b;
    repeat (3) @(posedge clk);
    @(negedge clk);
    q = serial_out_oe ? serial_out : 1'bz;
    @(posedge clk);
    serial_clock_in <= 1'b1;
    repeat (4) @(posedge clk);
    serial_clock_in <= 1'b0;
  endtask

  // select, then frame bits msb first
  task automatic send(input int n, input logic [28:0] v);
    logic q;
    @(posedge clk);
    chip_select <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = n - 1; i >= 0; i--)
      bit_io(v[i], q);
  endtask

  task automatic recv(input int n, output logic [32:0] v);
    v = '0;
    for (int i = n - 1; i >= 0; i--)
      bit_io(1'b0, v[i]);
  endtask

  // deselect long enough to be seen
  task automatic deselect();
    @(posedge clk);
    chip_select <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* dv/tb_sep_command_port.sv */
module tb_sep_command_port
  import sep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst_n;
  logic word_width_select;
  logic program_enable_pin;
  logic chip_select;
  logic serial_clock_in;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic busy;
  logic write_enabled;
  logic q;
  logic [32:0] got;
  int fails;
  int checks_done;
  int cycles;

  always #5 clk = ~clk;

  sep_command_port #(.PROG_CYCLES(20)) i_sep_command_port
  (
    .clk(clk),
    .rst_n(rst_n),
    .chip_select(chip_select),
    .serial_clock_in(serial_clock_in),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .word_width_select(word_width_select),
    .program_enable_pin(program_enable_pin),
    .busy(busy),
    .write_enabled(write_enabled)
  );

  sep_host_model i_sep_host_model
  (
    .clk(clk),
    .chip_select(chip_select),
    .serial_clock_in(serial_clock_in),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe)
  );

  task automatic check(input logic [32:0] g, input logic [32:0] e,
    input string m);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(negedge clk);
    check({32'h0, busy}, 33'h0, "busy stuck");
  endtask

  // one frame, deselect, then expect work started or not
  task automatic run(input int n, input logic [28:0] v, input logic w);
    i_sep_host_model.send(n, v);
    i_sep_host_model.deselect();
    @(negedge clk);
    check({32'h0, busy}, {32'h0, w}, "busy after deselect");
    wait_idle();
  endtask

  task automatic rd(input int n, input logic [28:0] v,
    input logic [32:0] e, input int k);
    i_sep_host_model.send(n, v);
    i_sep_host_model.recv(k, got);
    i_sep_host_model.deselect();
    check(got, e, "read data");
  endtask

  task automatic t_reset();
    @(negedge clk);
    check({31'h0, serial_out_oe, busy}, 33'h0, "idle outputs");
    check({32'h0, write_enabled}, 33'h0, "latch at reset");
  endtask

  // write with status poll while busy, ready, then release
  task automatic t_poll();
    i_sep_host_model.send(29, {1'b1, OP_WRITE, 10'h3FF, 16'hA5C3});
    i_sep_host_model.deselect();
    @(negedge clk);
    check({32'h0, busy}, 33'h1, "write not started");
    i_sep_host_model.send(0, '0);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({31'h0, serial_out_oe, serial_out}, 33'h2, "busy status");
    wait_idle();
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({31'h0, serial_out_oe, serial_out}, 33'h3, "ready");
    @(posedge clk);
    i_sep_host_model.bit_io(1'b1, q);
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({32'h0, serial_out_oe}, 33'h0, "no release");
    i_sep_host_model.deselect();
  endtask

  // reset in mid-run drops a set latch
  task automatic t_rerst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    word_width_select = 1'b1;
    program_enable_pin = 1'b1;
    fails = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    run(29, {1'b1, OP_WRITE, 10'h005, 16'h1234}, 1'b0);
    run(13, {1'b1, OP_SPECIAL, SUB_WEN, 8'h00}, 1'b0);
    check({32'h0, write_enabled}, 33'h1, "latch not set");
    t_poll();
    run(29, {1'b1, OP_WRITE, 10'h000, 16'h0F0F}, 1'b1);
    rd(13, {1'b1, OP_READ, 10'h3FF}, {1'b0, 16'hA5C3, 16'h0F0F}, 33);
    run(13, {1'b1, OP_ERASE, 10'h000}, 1'b1);
    @(posedge clk);
    program_enable_pin <= 1'b0;
    run(29, {1'b1, OP_WRITE, 10'h3FF, 16'h1111}, 1'b0);
    @(posedge clk);
    program_enable_pin <= 1'b1;
    rd(13, {1'b1, OP_READ, 10'h3FF}, {1'b0, 16'hA5C3, 16'hFFFF}, 33);
    run(13, {1'b1, OP_SPECIAL, SUB_ERASE_ALL_CMD, 8'h00}, 1'b1);
    rd(13, {1'b1, OP_READ, 10'h3FF}, {1'b0, 32'hFFFFFFFF}, 33);
    run(29, {1'b1, OP_SPECIAL, SUB_WRITE_ALL_CMD, 8'h00, 16'hC35A}, 1'b1);
    run(8, {1'b1, OP_ERASE, 5'h00}, 1'b0);
    @(posedge clk);
    word_width_select <= 1'b0;
    rd(14, {1'b1, OP_READ, 11'h7FF}, {17'h0, 8'h5A, 8'hC3}, 17);
    word_width_select <= 1'b1;
    @(posedge clk);
    program_enable_pin <= 1'b0;
    run(13, {1'b1, OP_SPECIAL, SUB_WDIS, 8'h00}, 1'b0);
    check({32'h0, write_enabled}, 33'h0, "latch not cleared");
    @(posedge clk);
    program_enable_pin <= 1'b1;
    rd(13, {1'b1, OP_READ, 10'h000}, {1'b0, 32'hC35AC35A}, 33);
    run(29, {1'b1, OP_WRITE, 10'h000, 16'h0000}, 1'b0);
    rd(13, {1'b1, OP_READ, 10'h000}, {1'b0, 32'hC35AC35A}, 33);
    run(13, {1'b1, OP_SPECIAL, SUB_WEN, 8'h00}, 1'b0);
    check({32'h0, write_enabled}, 33'h1, "latch not set again");
    t_rerst();
    conclude();
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      conclude();
    end
  end
endmodule
